// ==== dcad_defines.vh ====
// Shared constants for the DDR3 command and address decode block.
`ifndef DCAD_DEFINES_VH
`define DCAD_DEFINES_VH
// Command codes on {RAS#, CAS#, WE#} with chip select low.
`define DCAD_CMD_MRS   3'h0
`define DCAD_CMD_REF   3'h1
`define DCAD_CMD_PRE   3'h2
`define DCAD_CMD_ACT   3'h3
`define DCAD_CMD_WR    3'h4
`define DCAD_CMD_RD    3'h5
`define DCAD_CMD_ZQ    3'h6
`define DCAD_CMD_NOP   3'h7
// Address bit positions with extra meaning.
`define DCAD_AP_BIT    10
`define DCAD_BC_BIT    12
`define DCAD_COL_MSB   9
// Additive latency selections.
`define DCAD_AL_ZERO   2'h0
`define DCAD_AL_CLM1   2'h1
`define DCAD_AL_CLM2   2'h2
// Burst lengths in words.
`define DCAD_BL_FULL   4'h8
`define DCAD_BL_CHOP   4'h4
`endif

// ==== dcad_burst_seq.v ====
// Burst word sequencer stepping on both crossings of the memory clock.
`timescale 1ns/1ps
`default_nettype none
module dcad_burst_seq (
    input  wire       mclk,
    input  wire       rstB,
    input  wire       start,
    input  wire [2:0] startCol,
    input  wire       len8,
    input  wire       interleave,
    input  wire       hold,
    input  wire       beatEdge,
    output reg        beatValid_q,
    output reg  [2:0] beatIdx_q,
    output reg        busy_q,
    output reg        done_q
);
    // ----------------------------------------------------------------
    // Word order within a burst
    // ----------------------------------------------------------------
    // A chopped burst wraps inside its nibble, a full burst inside eight words.
    function [2:0] wordOrder;
        input [2:0] col;
        input [2:0] n;
        input       full;
        input       intl;
        reg   [2:0] s;
        begin
            s = col + n;
            if (intl) begin
                wordOrder = col ^ n;
            end else if (full) begin
                wordOrder = s;
            end else begin
                wordOrder = {col[2], s[1:0]};
            end
        end
    endfunction

    reg [2:0] col_q;
    reg [2:0] cnt_q;
    reg       full_q;
    reg       intl_q;
    wire [2:0] lastIdx = full_q ? 3'h7 : 3'h3;

    always @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            col_q       <= 3'h0;
            cnt_q       <= 3'h0;
            full_q      <= 1'b0;
            intl_q      <= 1'b0;
            beatValid_q <= 1'b0;
            beatIdx_q   <= 3'h0;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            beatValid_q <= 1'b0;
            done_q      <= 1'b0;
            if (start) begin
                col_q  <= startCol;
                cnt_q  <= 3'h0;
                full_q <= len8;
                intl_q <= interleave;
                busy_q <= 1'b1;
            end else if (busy_q && beatEdge && !hold) begin
                beatValid_q <= 1'b1;
                beatIdx_q   <= wordOrder(col_q, cnt_q, full_q, intl_q);
                cnt_q       <= cnt_q + 3'h1;
                if (cnt_q == lastIdx) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule // dcad_burst_seq
`default_nettype wire

// ==== dcad_cmd_decode.v ====
// Command, clock-enable and address decode of an eight-bank x16 DDR3 device.
`timescale 1ns/1ps
`default_nettype none
`include "dcad_defines.vh"
// What this block does
// - Capture inputs only at CK rise crossing.
// - Read words step on both clock crossings.
// - CKE low freezes clock, command outputs, burst.
// - CKE low with banks idle enters low power.
// - Bank address selects one of eight banks.
// - Activate takes thirteen address bits as row.
// - Read and write use A0-A9 as column.
// - Mode register set loads address as opcode.
// - A10 high on access means auto-precharge.
// - A10 on precharge selects one or all.
// - Burst length four or eight words.
// - Burst order sequential or interleaved.
// - Additive latency zero, CL-1 or CL-2.
// - Eight banks, eight-word prefetch per access.
// - Chip select high masks every command.
// - RAS low, CAS high: activate or precharge.
// - RAS high, CAS low: read or write.
// - A12 low chops the burst on the fly.
module dcad_cmd_decode #(
    parameter BANKS   = 8,
    parameter BA_W    = 3,
    parameter ADDR_W  = 13,
    parameter CL_W    = 5
) (
    input  wire              mclk,
    input  wire              rst_b,
    input  wire              ckPin,
    input  wire              ckBPin,
    input  wire              ckePin,
    input  wire              csBPin,
    input  wire              rasBPin,
    input  wire              casBPin,
    input  wire              weBPin,
    input  wire [BA_W-1:0]   baPin,
    input  wire [ADDR_W-1:0] addrPin,
    input  wire              cfgBurst8,
    input  wire              cfgInterleave,
    input  wire [1:0]        cfgAlSel,
    input  wire [CL_W-1:0]   cfgCasLat,
    output reg               cmdValid_q,
    output reg  [2:0]        cmdCode_q,
    output reg  [BA_W-1:0]   bankSel_q,
    output reg  [ADDR_W-1:0] rowAddr_q,
    output reg  [9:0]        colAddr_q,
    output reg               autoPre_q,
    output reg               preAll_q,
    output reg               burstChop_q,
    output reg               modeLoad_q,
    output reg  [BA_W-1:0]   modeSel_q,
    output reg  [ADDR_W-1:0] modeOpcode_q,
    output reg  [BANKS-1:0]  bankOpen_q,
    output reg               powerDown_q,
    output reg               selfRefresh_q,
    output reg               clockRun_q,
    output reg  [CL_W-1:0]   addLat_q,
    output wire              beatValid_q,
    output wire [2:0]        beatIdx_q,
    output wire              burstBusy_q,
    output wire              burstDone_q
);
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] rstSync_q;
    wire      rstB = rstSync_q[1];

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    // All pins ride the same two stages, so command and clock stay aligned.
    localparam PIN_W = 7 + BA_W + ADDR_W;
    wire [PIN_W-1:0] pinBus = {ckPin, ckBPin, ckePin, csBPin, rasBPin, casBPin,
                               weBPin, baPin, addrPin};
    reg  [PIN_W-1:0] pinMeta_q;
    reg  [PIN_W-1:0] pinSync_q;

    always @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            pinMeta_q <= {PIN_W{1'b0}};
            pinSync_q <= {PIN_W{1'b0}};
        end else begin
            pinMeta_q <= pinBus;
            pinSync_q <= pinMeta_q;
        end
    end

    wire              ckS   = pinSync_q[PIN_W-1];
    wire              ckBS  = pinSync_q[PIN_W-2];
    wire              ckeS  = pinSync_q[PIN_W-3];
    wire              csBS  = pinSync_q[PIN_W-4];
    wire [2:0]        cmdS  = pinSync_q[PIN_W-5:PIN_W-7];
    wire [BA_W-1:0]   baS   = pinSync_q[ADDR_W+BA_W-1:ADDR_W];
    wire [ADDR_W-1:0] addrS = pinSync_q[ADDR_W-1:0];

    // ----------------------------------------------------------------
    // Clock crossing detection
    // ----------------------------------------------------------------
    // CK high with CK# low counts as the rising crossing; the reverse as falling.
    reg  ckHi_q;
    wire ckHiNow  = ckS & ~ckBS;
    wire ckLoNow  = ~ckS & ckBS;
    wire riseEdge = ckHiNow & ~ckHi_q;
    wire fallEdge = ckLoNow & ckHi_q;

    always @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            ckHi_q <= 1'b0;
        end else if (riseEdge) begin
            ckHi_q <= 1'b1;
        end else if (fallEdge) begin
            ckHi_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Command decode at the rising crossing
    // ----------------------------------------------------------------
    wire decodeOn = riseEdge & clockRun_q & ~csBS;
    wire isAct    = decodeOn && cmdS == `DCAD_CMD_ACT;
    wire isPre    = decodeOn && cmdS == `DCAD_CMD_PRE;
    wire isRd     = decodeOn && cmdS == `DCAD_CMD_RD;
    wire isWr     = decodeOn && cmdS == `DCAD_CMD_WR;
    wire isMrs    = decodeOn && cmdS == `DCAD_CMD_MRS;
    wire isRef    = decodeOn && cmdS == `DCAD_CMD_REF;
    wire isAccess = isRd | isWr;
    wire allIdle  = (bankOpen_q == {BANKS{1'b0}});
    wire ckeFall  = riseEdge & clockRun_q & ~ckeS;

    reg [BA_W-1:0] apBank_q;
    reg            apPending_q;

    always @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            cmdValid_q   <= 1'b0;
            cmdCode_q    <= `DCAD_CMD_NOP;
            bankSel_q    <= {BA_W{1'b0}};
            rowAddr_q    <= {ADDR_W{1'b0}};
            colAddr_q    <= 10'h000;
            autoPre_q    <= 1'b0;
            preAll_q     <= 1'b0;
            burstChop_q  <= 1'b0;
            modeLoad_q   <= 1'b0;
            modeSel_q    <= {BA_W{1'b0}};
            modeOpcode_q <= {ADDR_W{1'b0}};
        end else begin
            cmdValid_q <= 1'b0;
            modeLoad_q <= 1'b0;
            if (decodeOn && cmdS != `DCAD_CMD_NOP) begin
                cmdValid_q <= 1'b1;
                cmdCode_q  <= cmdS;
                bankSel_q  <= baS;
                autoPre_q  <= 1'b0;
                preAll_q   <= 1'b0;
            end
            if (isAct) begin
                rowAddr_q <= addrS;
            end
            if (isAccess) begin
                colAddr_q   <= addrS[`DCAD_COL_MSB:0];
                autoPre_q   <= addrS[`DCAD_AP_BIT];
                burstChop_q <= ~addrS[`DCAD_BC_BIT];
            end
            if (isPre) begin
                preAll_q <= addrS[`DCAD_AP_BIT];
            end
            if (isMrs) begin
                modeLoad_q   <= 1'b1;
                modeSel_q    <= baS;
                modeOpcode_q <= addrS;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bank state
    // ----------------------------------------------------------------
    // Only one auto-precharge is tracked; a new access replaces it, which
    // matches a single data path that serves one burst at a time.
    always @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            bankOpen_q  <= {BANKS{1'b0}};
            apBank_q    <= {BA_W{1'b0}};
            apPending_q <= 1'b0;
        end else begin
            if (burstDone_q && apPending_q) begin
                bankOpen_q[apBank_q] <= 1'b0;
                apPending_q          <= 1'b0;
            end
            if (isAct) begin
                bankOpen_q[baS] <= 1'b1;
            end else if (isPre && addrS[`DCAD_AP_BIT]) begin
                bankOpen_q <= {BANKS{1'b0}};
            end else if (isPre) begin
                bankOpen_q[baS] <= 1'b0;
            end else if (isAccess) begin
                apBank_q    <= baS;
                apPending_q <= addrS[`DCAD_AP_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock enable, power-down and self refresh
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            clockRun_q    <= 1'b1;
            powerDown_q   <= 1'b0;
            selfRefresh_q <= 1'b0;
        end else if (riseEdge) begin
            clockRun_q <= ckeS;
            if (ckeFall && allIdle && isRef) begin
                selfRefresh_q <= 1'b1;
            end else if (ckeFall && allIdle) begin
                powerDown_q <= 1'b1;
            end else if (ckeS) begin
                powerDown_q   <= 1'b0;
                selfRefresh_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Additive latency
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            addLat_q <= {CL_W{1'b0}};
        end else if (cfgAlSel == `DCAD_AL_CLM1) begin
            addLat_q <= cfgCasLat - {{(CL_W-1){1'b0}}, 1'b1};
        end else if (cfgAlSel == `DCAD_AL_CLM2) begin
            addLat_q <= cfgCasLat - {{(CL_W-2){1'b0}}, 2'h2};
        end else begin
            addLat_q <= {CL_W{1'b0}};
        end
    end

    // ----------------------------------------------------------------
    // Burst sequencing
    // ----------------------------------------------------------------
    // A chopped access moves four words of the eight-word prefetch.
    dcad_burst_seq i_dcad_burst_seq (
        .mclk        (mclk),
        .rstB        (rstB),
        .start       (isAccess),
        .startCol    (addrS[2:0]),
        .len8        (cfgBurst8 & addrS[`DCAD_BC_BIT]),
        .interleave  (cfgInterleave),
        .hold        (~clockRun_q),
        .beatEdge    (riseEdge | fallEdge),
        .beatValid_q (beatValid_q),
        .beatIdx_q   (beatIdx_q),
        .busy_q      (burstBusy_q),
        .done_q      (burstDone_q)
    );
endmodule // dcad_cmd_decode
`default_nettype wire

// ==== dcad_cmd_decode_props.sv ====
// Concurrent checks on the ports of the command and address decode block.
`timescale 1ns/1ps
`default_nettype none
module dcad_cmd_decode_props #(
    parameter BANKS  = 8,
    parameter BA_W   = 3,
    parameter ADDR_W = 13,
    parameter CL_W   = 5
) (
    input wire logic             mclk,
    input wire logic             rst_b,
    input wire logic             cmdValid_q,
    input wire logic [2:0]       cmdCode_q,
    input wire logic [BA_W-1:0]  bankSel_q,
    input wire logic [BANKS-1:0] bankOpen_q,
    input wire logic             preAll_q,
    input wire logic             modeLoad_q,
    input wire logic             clockRun_q,
    input wire logic             powerDown_q,
    input wire logic             selfRefresh_q,
    input wire logic             beatValid_q,
    input wire logic             burstBusy_q,
    input wire logic             burstDone_q,
    input wire logic [1:0]       cfgAlSel,
    input wire logic [CL_W-1:0]  cfgCasLat,
    input wire logic [CL_W-1:0]  addLat_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    property p_one_cmd; cmdValid_q |=> !cmdValid_q; endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("command pulse too long");
    property p_act_open; cmdValid_q && cmdCode_q == 3'h3 |-> bankOpen_q[bankSel_q]; endproperty
    a_act_open: assert property (p_act_open) else $error("activate left bank shut");
    property p_pre_one; cmdValid_q && cmdCode_q == 3'h2 && !preAll_q |-> !bankOpen_q[bankSel_q];
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("precharge left bank open");
    property p_pre_all; cmdValid_q && cmdCode_q == 3'h2 && preAll_q |-> bankOpen_q == '0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank");
    property p_mode; modeLoad_q |-> cmdValid_q && cmdCode_q == 3'h0; endproperty
    a_mode: assert property (p_mode) else $error("mode load without mode set");
    property p_freeze; !$past(clockRun_q) |-> !beatValid_q; endproperty
    a_freeze: assert property (p_freeze) else $error("beat while clock halted");
    property p_low_power; powerDown_q || selfRefresh_q |-> !clockRun_q && !(powerDown_q &&
        selfRefresh_q); endproperty
    a_low_power: assert property (p_low_power) else $error("low power with clock");
    property p_access; cmdValid_q && cmdCode_q[2:1] == 2'h2 |-> burstBusy_q; endproperty
    a_access: assert property (p_access) else $error("access started no burst");
    property p_done; burstDone_q |-> beatValid_q && !burstBusy_q; endproperty
    a_done: assert property (p_done) else $error("burst end not on last beat");
    property p_al; (cfgAlSel == 2'h1 && $stable(cfgAlSel) && $stable(cfgCasLat)) [*5] |->
        addLat_q == cfgCasLat - 1'b1; endproperty
    a_al: assert property (p_al) else $error("additive latency wrong");
endmodule // dcad_cmd_decode_props
`default_nettype wire

// ==== dcad_ctrl_model.sv ====
// Memory controller model driving the clock, command and address pins.
`timescale 1ns/1ps
`default_nettype none
module dcad_ctrl_model (
    output logic        ckPin,
    output logic        ckBPin,
    output logic        ckePin,
    output logic        csBPin,
    output logic        rasBPin,
    output logic        casBPin,
    output logic        weBPin,
    output logic [2:0]  baPin,
    output logic [12:0] addrPin
);
    // A controller's system clock runs free, so CK does not stop between commands.
    initial begin
        ckPin = 1'b0;
        ckBPin = 1'b1;
        ckePin = 1'b1;
        csBPin = 1'b1;
        {rasBPin, casBPin, weBPin} = 3'h7;
        baPin = 3'h0;
        addrPin = 13'h0000;
        #1.3;
        forever begin
            #32 ckPin = ~ckPin;
            ckBPin = ~ckPin;
        end
    end
    // Pins change at the falling edge, half a period clear of the sampling crossing.
    // Runs are far shorter than one refresh interval, so no refresh stream is owed.
    task automatic issue(input logic [2:0] cmd, input logic [2:0] ba, input logic [12:0] addr,
                         input logic csB, input logic cke);
        @(negedge ckPin);
        csBPin <= csB;
        ckePin <= cke;
        {rasBPin, casBPin, weBPin} <= cmd;
        baPin <= ba;
        addrPin <= addr;
        @(negedge ckPin);
        csBPin <= 1'b1;
        {rasBPin, casBPin, weBPin} <= 3'h7;
        // Hold time is over, so the lines show the inverse rather than the old value.
        baPin <= ~ba;
        addrPin <= ~addr;
    endtask
endmodule // dcad_ctrl_model
`default_nettype wire

// ==== test_dcad_cmd_decode.sv ====
// Self-checking testbench for the command and address decode block.
`timescale 1ns/1ps
`default_nettype none
module test_dcad_cmd_decode;
    logic mclk, rst_b, ckPin, ckBPin, ckePin, csBPin, rasBPin, casBPin, weBPin;
    logic cfgBurst8, cfgInterleave, cmdValid_q, autoPre_q, preAll_q, burstChop_q, modeLoad_q;
    logic powerDown_q, selfRefresh_q, clockRun_q, beatValid_q, burstBusy_q, burstDone_q;
    logic [2:0]  baPin, cmdCode_q, bankSel_q, modeSel_q, beatIdx_q;
    logic [12:0] addrPin, rowAddr_q, modeOpcode_q;
    logic [9:0]  colAddr_q;
    logic [7:0]  bankOpen_q;
    logic [1:0]  cfgAlSel;
    logic [4:0]  cfgCasLat, addLat_q;
    logic [2:0]  beats[$];
    int          failures, n_compared, nCmd, n0, b;
    dcad_cmd_decode i_dcad_cmd_decode (.*);
    dcad_ctrl_model i_dcad_ctrl_model (.*);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (cmdValid_q === 1'b1) nCmd <= nCmd + 1;
        if (beatValid_q === 1'b1) beats.push_back(beatIdx_q);
    end
    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [2:0] c, input logic [2:0] ba, input logic [12:0] a);
        i_dcad_ctrl_model.issue(c, ba, a, 1'b0, ckePin);
    endtask
    task automatic burst(input logic [2:0] c, input logic [2:0] ba, input logic [12:0] a);
        logic [2:0] col, idx;
        int len, k;
        col = a[2:0];
        beats.delete();
        cmd(c, ba, a);
        // Length is taken after the command so that a setting changed just before applies.
        len = (cfgBurst8 && a[12]) ? 8 : 4;
        for (k = 0; k < 200 && burstDone_q !== 1'b1; k++) @(posedge mclk);
        check("burst ended", 13'(k < 200), 13'h1);
        @(posedge mclk);
        check("beat count", 13'(beats.size()), 13'(len));
        for (k = 0; k < len; k++) begin
            idx = cfgInterleave ? col ^ k[2:0] :
                  (len == 8 ? col + k[2:0] : {col[2], col[1:0] + k[1:0]});
            check("beat index", 13'(beats[k]), 13'(idx));
        end
    endtask
    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #60000;
        failures++;
        end_sim();
    end
    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        cfgBurst8 = 1'b1;
        cfgInterleave = 1'b0;
        cfgAlSel = 2'h0;
        cfgCasLat = 5'h0b;
        repeat (10) @(posedge mclk);
        check("reset code", 13'(cmdCode_q), 13'h7);
        check("reset run", 13'(clockRun_q), 13'h1);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        cmd(3'h3, 3'h5, 13'h1abc);
        check("cmd count", 13'(nCmd), 13'h1);
        check("act code", 13'(cmdCode_q), 13'h3);
        check("act bank", 13'(bankSel_q), 13'h5);
        check("act row", rowAddr_q, 13'h1abc);
        cmd(3'h0, 3'h2, 13'h0a5a);
        check("mode sel", 13'(modeSel_q), 13'h2);
        check("mode op", modeOpcode_q, 13'h0a5a);
        burst(3'h5, 3'h5, 13'h17f3);
        check("col", 13'(colAddr_q), 13'h3f3);
        check("auto pre", 13'(autoPre_q), 13'h1);
        check("no chop", 13'(burstChop_q), 13'h0);
        check("closed", 13'(bankOpen_q), 13'h0);
        cmd(3'h3, 3'h2, 13'h0155);
        @(posedge mclk);
        cfgInterleave <= 1'b1;
        burst(3'h4, 3'h2, 13'h0006);
        check("wr code", 13'(cmdCode_q), 13'h4);
        check("chop", 13'(burstChop_q), 13'h1);
        check("stays open", 13'(bankOpen_q), 13'h4);
        @(posedge mclk);
        cfgInterleave <= 1'b0;
        cfgBurst8 <= 1'b0;
        burst(3'h5, 3'h2, 13'h1005);
        n0 = nCmd;
        i_dcad_ctrl_model.issue(3'h3, 3'h7, 13'h0000, 1'b1, 1'b1);
        check("masked", 13'(nCmd), 13'(n0));
        for (b = 0; b < 8; b++) cmd(3'h3, 3'(b), 13'(b));
        check("all open", 13'(bankOpen_q), 13'hff);
        cmd(3'h2, 3'h2, 13'h0000);
        check("pre one", 13'({preAll_q, bankOpen_q}), 13'h0fb);
        cmd(3'h2, 3'h0, 13'h0400);
        check("pre all", 13'({preAll_q, bankOpen_q}), 13'h100);
        i_dcad_ctrl_model.issue(3'h7, 3'h0, 13'h0000, 1'b0, 1'b0);
        check("power down", 13'({powerDown_q, clockRun_q}), 13'h2);
        n0 = nCmd;
        cmd(3'h3, 3'h1, 13'h0001);
        check("frozen", 13'({nCmd == n0, bankOpen_q}), 13'h100);
        i_dcad_ctrl_model.issue(3'h7, 3'h0, 13'h0000, 1'b0, 1'b1);
        check("wake", 13'({powerDown_q, clockRun_q}), 13'h1);
        i_dcad_ctrl_model.issue(3'h1, 3'h0, 13'h0000, 1'b0, 1'b0);
        check("self refresh", 13'(selfRefresh_q), 13'h1);
        i_dcad_ctrl_model.issue(3'h7, 3'h0, 13'h0000, 1'b0, 1'b1);
        check("exit refresh", 13'(selfRefresh_q), 13'h0);
        // Clock suspend with a bank open: the burst must wait and no power-down is entered.
        cmd(3'h3, 3'h3, 13'h0000);
        beats.delete();
        i_dcad_ctrl_model.issue(3'h5, 3'h3, 13'h1000, 1'b0, 1'b0);
        repeat (20) @(posedge mclk);
        check("held", 13'({burstBusy_q, powerDown_q, 8'(beats.size())}), 13'h200);
        i_dcad_ctrl_model.issue(3'h7, 3'h0, 13'h0000, 1'b0, 1'b1);
        repeat (40) @(posedge mclk);
        check("resumed", 13'({burstBusy_q, 8'(beats.size())}), 13'h004);
        for (b = 0; b < 4; b++) begin
            @(posedge mclk);
            cfgAlSel <= 2'(b);
            repeat (8) @(posedge mclk);
            check("add lat", 13'(addLat_q), b == 1 ? 13'ha : (b == 2 ? 13'h9 : 13'h0));
        end
        end_sim();
    end
endmodule // test_dcad_cmd_decode
bind dcad_cmd_decode dcad_cmd_decode_props #(.BANKS(BANKS), .BA_W(BA_W), .ADDR_W(ADDR_W),
    .CL_W(CL_W)) i_props (.*);
`default_nettype wire
